// ==== common/appl_seq_pkg.sv ====
// constants, types and decode for the applicator signal sequencer
// assumes a 200 MHz system clock and an apb slave at byte addresses
package appl_seq_pkg;
  // clock and time base
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned TIME_W = 16;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DWELL = 8'h04;
  localparam logic [7:0] ADDR_BLOW = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // control field positions
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_VACV_BIT = 1;
  localparam int unsigned CTRL_PNEU_BIT = 2;
  localparam int unsigned CTRL_EXT_BIT = 3;
  localparam int unsigned CTRL_TYPE_LSB = 4;
  // reset values, times in ticks of 1 ms
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] DWELL_RST = 16'h0064;
  localparam logic [15:0] BLOW_RST = 16'h0032;
  // synchronised pin inputs
  localparam int unsigned IN_W = 6;
  localparam int unsigned IN_HOME = 0;
  localparam int unsigned IN_TOUCH = 1;
  localparam int unsigned IN_START = 2;
  localparam int unsigned IN_START_OPT = 3;
  localparam int unsigned IN_INHIBIT = 4;
  localparam int unsigned IN_PANEL = 5;

  typedef enum logic [3:0] {
    TYPE_TAMP_SENSOR = 4'h0,
    TYPE_TAMP = 4'h1,
    TYPE_TAMP_BLOW = 4'h2,
    TYPE_TAMP2_SENSOR = 4'h3,
    TYPE_AIR_BLOW = 4'h4,
    TYPE_TAMP_REVERSE = 4'h5,
    TYPE_DIRECT = 4'h6,
    TYPE_TAMP_AUX = 4'h7,
    TYPE_ORING = 4'h8,
    TYPE_WIPE_BLOW = 4'h9,
    TYPE_WIPE_TIMED = 4'hA,
    TYPE_WIPE_SENSOR = 4'hB
  } appl_type_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DISPENSE = 5'h02,
    ST_PRESS = 5'h04,
    ST_BLOW = 5'h08,
    ST_RETURN = 5'h10
  } seq_state_t;

  typedef struct packed {
    logic air;
    logic vac;
    logic cyl;
    logic blow;
    logic sensor;
    logic home;
    logic aux;
  } feat_t;

  // signals in use per applicator type and option bits
  function automatic feat_t type_feat(input appl_type_t ty,
                                      input logic vacv, input logic pneu,
                                      input logic ext);
    feat_t f;
    f = '0;
    unique case (ty)
      TYPE_TAMP_SENSOR: f = '{1'b1, vacv, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      TYPE_TAMP: f = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      TYPE_TAMP_BLOW: f = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      TYPE_TAMP2_SENSOR: f = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      TYPE_AIR_BLOW: f = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      TYPE_TAMP_REVERSE: f = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      TYPE_DIRECT: f = '{pneu, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      TYPE_TAMP_AUX: f = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, ext};
      TYPE_ORING: f = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      TYPE_WIPE_BLOW: f = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      TYPE_WIPE_TIMED: f = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      TYPE_WIPE_SENSOR: f = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      default: f = '0;
    endcase
    return f;
  endfunction : type_feat
endpackage : appl_seq_pkg

// ==== common/appl_timer_if.sv ====
// load and status link between the sequencer and its duration timer
// assumes both ends on the same clock
interface appl_timer_if;
  logic load;
  logic [15:0] ticks;
  logic busy;
  modport seq (output load, output ticks, input busy);
  modport timer (input load, input ticks, output busy);
endinterface : appl_timer_if

// ==== rtl/appl_timer.sv ====
// millisecond duration timer for dwell and blow-on times
// assumes load is a one-cycle pulse from the sequencer
module appl_timer
  import appl_seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // sequencer side
  appl_timer_if.timer tif
);
  typedef struct packed {
    logic [31:0] pre;
    logic [15:0] cnt;
    logic busy;
  } tmr_t;

  tmr_t t;
  tmr_t next_t;

  always_comb begin
    next_t = t;
    if (tif.load) begin
      next_t.cnt = tif.ticks;
      next_t.pre = '0;
      next_t.busy = (tif.ticks != 16'h0000);
    end else if (t.busy) begin
      if (t.pre >= TICK_CYCLES - 1) begin
        next_t.pre = '0;
        next_t.cnt = t.cnt - 16'h0001;
        if (t.cnt == 16'h0001) begin
          next_t.busy = 1'b0;
        end
      end else begin
        next_t.pre = t.pre + 32'h00000001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      t <= '0;
    end else if (i_ce) begin
      t <= next_t;
    end
  end

  assign tif.busy = t.busy;
endmodule : appl_timer

// ==== rtl/appl_sequencer.sv ====
// applicator signal sequencer with apb control and status registers
// assumes pins are asynchronous, label-done comes from labeler logic
// Contract
// - the interface runs as applicator or plc interface by a mode bit.
// - cylinder is on for the dwell time, or until touch-down on sensor types.
// - airstream support is on from start until cylinder comes on.
// - vacuum is on from start until cylinder goes off.
// - blow-on comes on when application ends, for the blow-on time.
// - touch-down is read only on sensor types and ignored on timed ones.
// - direct dispense drives airstream only with a pneumatic edge.
// - the dedicated tamp-aux output exists only on the extended interface.
// - some types also get outputs they do not need, like blow-on.
// - on types with a home signal, a cycle completes only when home is active again after return; other types go straight to idle.
// - inhibit blocks start at both interfaces but not the panel button.
// - offline follows the inhibit input.
module appl_sequencer
  import appl_seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // applicator and panel pins
  input wire logic i_home,
  input wire logic i_touch_down,
  input wire logic i_start,
  input wire logic i_start_opt,
  input wire logic i_inhibit,
  input wire logic i_panel_trig,
  // labeler logic
  input wire logic i_label_done,
  // applicator outputs
  output logic o_cylinder,
  output logic o_airstream,
  output logic o_vacuum,
  output logic o_blow_on,
  output logic o_aux,
  output logic o_offline
);
  typedef struct packed {
    logic [IN_W-1:0] sync1;
    logic [IN_W-1:0] sync2;
    logic [IN_W-1:0] prev;
    seq_state_t state;
    logic [7:0] ctrl;
    logic [15:0] dwell;
    logic [15:0] blow;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic load;
    logic [15:0] ticks;
    logic cyl;
    logic air;
    logic vac;
    logic blow_o;
    logic aux;
    logic offline;
  } seq_t;

  seq_t s;
  seq_t next_s;
  feat_t f;
  logic start_ev;
  logic panel_ev;
  logic trig;
  logic applic;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  appl_timer_if tif();

  appl_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .tif(tif)
  );

  assign tif.load = s.load;
  assign tif.ticks = s.ticks;

  function automatic logic mapped(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_DWELL) || (a == ADDR_BLOW) ||
           (a == ADDR_STATUS);
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    next_s = s;
    f = type_feat(appl_type_t'(s.ctrl[CTRL_TYPE_LSB +: 4]),
                  s.ctrl[CTRL_VACV_BIT], s.ctrl[CTRL_PNEU_BIT],
                  s.ctrl[CTRL_EXT_BIT]);
    next_s.sync1 = {i_panel_trig, i_inhibit, i_start_opt, i_start,
                    i_touch_down, i_home};
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    start_ev = (s.sync2[IN_START] & ~s.prev[IN_START]) |
               (s.sync2[IN_START_OPT] & ~s.prev[IN_START_OPT]);
    panel_ev = s.sync2[IN_PANEL] & ~s.prev[IN_PANEL];
    trig = (start_ev & ~s.sync2[IN_INHIBIT]) | panel_ev;
    applic = s.ctrl[CTRL_MODE_BIT];
    next_s.load = 1'b0;
    unique case (s.state)
      ST_IDLE: begin
        if (applic && trig) begin
          next_s.state = ST_DISPENSE;
        end
      end
      ST_DISPENSE: begin
        if (i_label_done) begin
          if (f.cyl) begin
            next_s.state = ST_PRESS;
            next_s.load = 1'b1;
            next_s.ticks = s.dwell;
          end else if (f.blow) begin
            next_s.state = ST_BLOW;
            next_s.load = 1'b1;
            next_s.ticks = s.blow;
          end else begin
            next_s.state = f.home ? ST_RETURN : ST_IDLE;
          end
        end
      end
      ST_PRESS: begin
        if (!s.load && (f.sensor ? s.sync2[IN_TOUCH] : !tif.busy)) begin
          if (f.blow) begin
            next_s.state = ST_BLOW;
            next_s.load = 1'b1;
            next_s.ticks = s.blow;
          end else begin
            next_s.state = f.home ? ST_RETURN : ST_IDLE;
          end
        end
      end
      ST_BLOW: begin
        if (!s.load && !tif.busy) begin
          next_s.state = f.home ? ST_RETURN : ST_IDLE;
        end
      end
      ST_RETURN: begin
        if (s.sync2[IN_HOME]) begin
          next_s.state = ST_IDLE;
        end
      end
      default: next_s.state = ST_IDLE;
    endcase
    if (!applic) begin
      next_s.state = ST_IDLE;
    end
    next_s.air = (next_s.state == ST_DISPENSE) & f.air;
    next_s.vac = ((next_s.state == ST_DISPENSE) |
                  (next_s.state == ST_PRESS)) & f.vac;
    next_s.cyl = (next_s.state == ST_PRESS) & f.cyl;
    next_s.blow_o = (next_s.state == ST_BLOW) & f.blow;
    // aux output only with extended interface
    next_s.aux = (next_s.state == ST_PRESS) & f.aux;
    next_s.offline = s.sync2[IN_INHIBIT];
    // apb: setup captures read data, one wait cycle then ready
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (i_psel && !i_penable) begin
      unique case (i_paddr)
        ADDR_CTRL: next_s.prdata = {24'h000000, s.ctrl};
        ADDR_DWELL: next_s.prdata = {16'h0000, s.dwell};
        ADDR_BLOW: next_s.prdata = {16'h0000, s.blow};
        ADDR_STATUS: next_s.prdata = {15'h0000, s.offline, s.aux, s.blow_o,
                                      s.vac, s.air, s.cyl, s.state, s.sync2};
        default: next_s.prdata = 32'h00000000;
      endcase
    end
    if (i_psel && i_penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !mapped(i_paddr);
    end
    if (i_psel && i_penable && s.pready && i_pwrite) begin
      unique case (i_paddr)
        ADDR_CTRL: next_s.ctrl = 8'(merge({24'h000000, s.ctrl}, i_pwdata,
                                          i_pstrb));
        ADDR_DWELL: next_s.dwell = 16'(merge({16'h0000, s.dwell}, i_pwdata,
                                             i_pstrb));
        ADDR_BLOW: next_s.blow = 16'(merge({16'h0000, s.blow}, i_pwdata,
                                           i_pstrb));
        default: next_s.ctrl = s.ctrl;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '{sync1: '0, sync2: '0, prev: '0, state: ST_IDLE,
             ctrl: CTRL_RST, dwell: DWELL_RST, blow: BLOW_RST,
             prdata: '0, pready: 1'b0, pslverr: 1'b0, load: 1'b0,
             ticks: '0, cyl: 1'b0, air: 1'b0, vac: 1'b0, blow_o: 1'b0,
             aux: 1'b0, offline: 1'b0};
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_prdata = s.prdata;
  assign o_pready = s.pready;
  assign o_pslverr = s.pslverr;
  assign o_cylinder = s.cyl;
  assign o_airstream = s.air;
  assign o_vacuum = s.vac;
  assign o_blow_on = s.blow_o;
  assign o_aux = s.aux;
  assign o_offline = s.offline;

  AST_PLC_IDLE: assert property (i_ce && !s.ctrl[CTRL_MODE_BIT]
    |=> s.state == ST_IDLE)
    else $error("plc mode left sequencer active");
  AST_TOUCH_ENDS: assert property (i_ce && s.state == ST_PRESS
    && f.sensor && !s.load && s.sync2[IN_TOUCH] |=> !o_cylinder)
    else $error("cylinder held after touch-down");
  AST_AIR_OFF: assert property ($rose(o_cylinder) |-> !o_airstream
    && $past(o_airstream, 1) == $past(f.air, 1))
    else $error("airstream on with cylinder");
  AST_VAC_OFF: assert property ($fell(o_cylinder) |-> !o_vacuum)
    else $error("vacuum after cylinder off");
  AST_BLOW_ON: assert property ($fell(o_cylinder) && $past(f.blow)
    && $past(s.ctrl[CTRL_MODE_BIT]) |-> o_blow_on)
    else $error("blow-on missing after application");
  AST_TIMED_HOLD: assert property (i_ce && s.state == ST_PRESS
    && !f.sensor && tif.busy && s.ctrl[CTRL_MODE_BIT] |=> s.state == ST_PRESS)
    else $error("timed press ended early");
  AST_VAC_VARIANT: assert property (o_vacuum |-> !(
    $past(s.ctrl[CTRL_TYPE_LSB +: 4]) == TYPE_TAMP_SENSOR &&
    !$past(s.ctrl[CTRL_VACV_BIT])))
    else $error("vacuum without vacuum variant");
  AST_DIRECT_AIR: assert property (o_airstream |-> !(
    $past(s.ctrl[CTRL_TYPE_LSB +: 4]) == TYPE_DIRECT &&
    !$past(s.ctrl[CTRL_PNEU_BIT])))
    else $error("airstream without pneumatic edge");
  AST_AUX_EXT: assert property (o_aux |-> $past(s.ctrl[CTRL_EXT_BIT]))
    else $error("aux output without extended interface");
  AST_HOME_WAIT: assert property (i_ce && s.state == ST_RETURN
    && !s.sync2[IN_HOME] && s.ctrl[CTRL_MODE_BIT] |=> s.state == ST_RETURN)
    else $error("cycle ended before home");
  AST_INHIBIT: assert property (i_ce && s.state == ST_IDLE
    && s.sync2[IN_INHIBIT] && !panel_ev |=> s.state == ST_IDLE)
    else $error("start accepted under inhibit");
  AST_OFFLINE: assert property (i_ce ##1 1'b1
    |-> o_offline == $past(s.sync2[IN_INHIBIT]))
    else $error("offline does not follow inhibit");
  AST_IDLE_QUIET: assert property (s.state == ST_IDLE |-> !o_cylinder
    && !o_airstream && !o_vacuum && !o_blow_on && !o_aux)
    else $error("output active while idle");
endmodule : appl_sequencer

// ==== testbench/appl_model.sv ====
// applicator model: plate travel driven by the cylinder output
// assumes the cylinder output arrives on the sequencer clock
module appl_model #(
  parameter int BACK_CYC = 30
) (
  // clock and cylinder
  input wire logic i_clk,
  input wire logic i_cylinder,
  // position sensors
  output logic o_home,
  output logic o_touch_down
);
  timeunit 1ns;
  timeprecision 100ps;
  int pos = 0;
  // plate goes out fast and comes back slowly
  always @(posedge i_clk) begin
    if (i_cylinder) begin
      pos <= (pos + 6 > BACK_CYC) ? BACK_CYC : pos + 6;
    end else if (pos > 0) begin
      pos <= pos - 1;
    end
  end
  assign o_home = (pos == 0);
  assign o_touch_down = (pos == BACK_CYC);
endmodule : appl_model

// ==== testbench/tb_applicator_signal_sequencer.sv ====
// testbench for the applicator signal sequencer
// assumes the package register map and 1 ms = 4 cycles
module tb_applicator_signal_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import appl_seq_pkg::*;
  localparam int TCK = 4;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, start = 0, panel = 0, inhibit = 0, done = 0;
  logic start_opt = 0, opt_sel = 0;
  logic home, touch, cyl, air, vac, blow, aux, offl, clr = 1;
  wire logic [4:0] outs = {aux, blow, vac, air, cyl};
  int errors = 0, n_tests = 0;
  int cnt [7];

  appl_sequencer #(.TICK_CYCLES(TCK)) dut_u (
    .i_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_home(home), .i_touch_down(touch), .i_start(start),
    .i_start_opt(start_opt), .i_inhibit(inhibit), .i_panel_trig(panel),
    .i_label_done(done), .o_cylinder(cyl), .o_airstream(air),
    .o_vacuum(vac), .o_blow_on(blow), .o_aux(aux), .o_offline(offl)
  );
  appl_model model_u (
    .i_clk(clk), .i_cylinder(cyl), .o_home(home), .o_touch_down(touch)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  // per-cycle tallies of outputs and of forbidden overlaps
  always @(posedge clk) begin
    if (clr) begin
      cnt = '{default: 0};
    end else begin
      for (int k = 0; k < 5; k++) begin
        cnt[k] += int'(outs[k]);
      end
      cnt[5] += int'(air & cyl);
      cnt[6] += int'(vac & blow);
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
      errors++;
    end
  endtask : chk

  task automatic rng(input string nm, input int lo, hi, got);
    n_tests++;
    if (got < lo || got > hi) begin
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      errors++;
    end
  endtask : rng

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      chk("pready", 32'h1, 32'h0);
      finish_test();
    end
  endtask : apb

  task automatic wait_out(input int k, input logic v);
    int n;
    n = 0;
    while (outs[k] !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      chk("output wait", 32'(v), 32'(outs[k]));
      finish_test();
    end
  endtask : wait_out

  task automatic start_cycle(input logic p);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    start <= !p & !opt_sel;
    start_opt <= !p & opt_sel;
    panel <= p;
    repeat (4) @(posedge clk);
    start <= 1'b0;
    start_opt <= 1'b0;
    panel <= 1'b0;
    repeat (6) @(posedge clk);
    done <= 1'b1;
    repeat (2) @(posedge clk);
    done <= 1'b0;
  endtask : start_cycle

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[10:6] !== 5'h01 && n < 300);
    chk("state idle", 32'h1, 32'(rd[10:6]));
    chk("outs idle", 32'h0, 32'(outs));
    if (rd[10:6] !== 5'h01) begin
      finish_test();
    end
  endtask : wait_idle

  task automatic run_cycle(input logic p);
    start_cycle(p);
    wait_idle();
  endtask : run_cycle

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk("outs reset", 32'h0, 32'({outs, offl}));
    apb(1'b1, ADDR_BLOW, 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h02);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl readback", 32'h2, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    start_cycle(1'b0);
    repeat (10) @(posedge clk);
    rng("plc outputs", 0, 0, cnt[0] + cnt[1] + cnt[2] + cnt[3]);
    $display("test plc mode done");
    apb(1'b1, ADDR_CTRL, 32'h03);
    start_cycle(1'b0);
    wait_out(3, 1'b1);
    wait_out(3, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("state return", 32'h10, 32'(rd[10:6]));
    wait_idle();
    rng("cyl sensor", 1, 20, cnt[0]);
    rng("air", 1, 20, cnt[1]);
    chk("air with cyl", 32'h0, 32'(cnt[5]));
    rng("vac", cnt[0] + 3, 60, cnt[2]);
    chk("vac with blow", 32'h0, 32'(cnt[6]));
    rng("blow", 2 * TCK - 1, 2 * TCK + 2, cnt[3]);
    $display("test sensor cycle done");
    apb(1'b1, ADDR_CTRL, 32'h01);
    run_cycle(1'b0);
    chk("vac plain", 32'h0, 32'(cnt[2]));
    apb(1'b1, ADDR_DWELL, 32'h3);
    apb(1'b1, ADDR_CTRL, 32'h11);
    run_cycle(1'b0);
    rng("cyl timed", 3 * TCK - 1, 3 * TCK + 2, cnt[0]);
    $display("test timed cycle done");
    inhibit <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h03);
    repeat (5) @(posedge clk);
    chk("offline on", 32'h1, 32'(offl));
    start_cycle(1'b0);
    repeat (10) @(posedge clk);
    rng("inhibited air", 0, 0, cnt[1] + cnt[2]);
    run_cycle(1'b1);
    rng("panel cyl", 1, 20, cnt[0]);
    inhibit <= 1'b0;
    repeat (5) @(posedge clk);
    chk("offline off", 32'h0, 32'(offl));
    $display("test inhibit done");
    opt_sel <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h41);
    run_cycle(1'b0);
    rng("opt air", 1, 20, cnt[1]);
    rng("opt blow", 2 * TCK - 1, 2 * TCK + 2, cnt[3]);
    chk("opt cyl", 32'h0, 32'(cnt[0]));
    opt_sel <= 1'b0;
    $display("test optional start done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ADDR_CTRL, 32'h61 + 32'(k) * 4);
      run_cycle(1'b0);
      chk("direct air", 32'(k), 32'(cnt[1] > 0));
      apb(1'b1, ADDR_CTRL, 32'h71 + 32'(k) * 8);
      run_cycle(1'b0);
      chk("aux", 32'(k), 32'(cnt[4] > 0));
    end
    $display("test direct and aux done");
    finish_test();
  end
endmodule : tb_applicator_signal_sequencer
